// file: uart_enh_pkg.sv
// Package for the enhanced UART control block.
// Assumes one system clock and a channel baud tick at 16x bit rate.
package uart_enh_pkg;

  // ------------------------------------------------------------
  // Register selection
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_MODEM_STATUS = 3'h0,
    SEL_TURNAROUND   = 3'h1,
    SEL_SCRATCH      = 3'h2,
    SEL_FEATURE      = 3'h3,
    SEL_ENHANCED     = 3'h4
  } reg_sel_t;

  // ------------------------------------------------------------
  // Field layouts
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] trig_table;
    logic       rs485_en;
    logic       irda_rx_inv;
    logic [3:0] hyst;
  } feature_control_t;

  typedef struct packed {
    logic       auto_cts;
    logic       auto_rts;
    logic       special_det;
    logic       enh_wr_en;
    logic [3:0] sw_flow;
  } enhanced_feature_t;

  typedef struct packed {
    logic [3:0] delay;
    logic       tx_disable;
    logic       rx_disable;
  } turnaround_t;

  // ------------------------------------------------------------
  // Positions, reset values, counts
  // ------------------------------------------------------------
  localparam int          MS_DSR_BIT      = 5;
  localparam int          MS_CTS_BIT      = 4;
  localparam int          MS_DDSR_BIT     = 1;
  localparam int          MS_DCTS_BIT     = 0;
  localparam logic [7:0]  SCRATCH_RST     = 8'hff;
  localparam logic [7:0]  FEATURE_RST     = 8'h00;
  localparam logic [7:0]  ENHANCED_RST    = 8'h00;
  localparam logic [1:0]  TABLE_D         = 2'h3;
  localparam logic [3:0]  SW_FLOW_DUAL    = 4'hf;
  localparam int          TICKS_PER_BIT   = 16;
  localparam int          LEVEL_W         = 7;

endpackage

// file: bit_tick_div.sv
// Divider from the 16x baud tick to a one-cycle bit-time pulse.
// Assumes baud_tick is a one-cycle pulse in the sys_clk domain.
`timescale 1ns/100ps
`default_nettype none
module bit_tick_div
  import uart_enh_pkg::*;
#(
  parameter int TICKS = TICKS_PER_BIT
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic restart,
  input  wire logic baud_tick,
  output var  logic bit_tick
);

  localparam int CW = $clog2(TICKS);

  logic [CW-1:0] cnt_q;

  // ------------------------------------------------------------
  // Bit period counter
  // ------------------------------------------------------------
  // bit period divider
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q    <= '0;
      bit_tick <= 1'b0;
    end else if (restart) begin
      cnt_q    <= '0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (baud_tick) begin
        if (cnt_q == CW'(TICKS - 1)) begin
          cnt_q    <= '0;
          bit_tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  bit_period_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    bit_tick |=> !bit_tick)
    else $error("bit tick wider than one cycle");

endmodule
`default_nettype wire

// file: flow_threshold.sv
// Hysteresis decode and receive flow thresholds.
// Assumes trigger levels of tables A to C come from the trigger logic.
`timescale 1ns/100ps
`default_nettype none
module flow_threshold
  import uart_enh_pkg::*;
#(
  parameter int W = LEVEL_W
) (
  input  wire logic [1:0]   trig_table,
  input  wire logic [3:0]   hyst_code,
  input  wire logic [W-1:0] rx_trig,
  input  wire logic [W-1:0] next_up,
  input  wire logic [W-1:0] next_dn,
  output var  logic [W-1:0] upper,
  output var  logic [W-1:0] lower
);

  function automatic logic [W-1:0] hyst_chars(input logic [3:0] c);
    case (c)
      4'h0:    hyst_chars = W'(0);
      4'h1:    hyst_chars = W'(4);
      4'h2:    hyst_chars = W'(6);
      4'h3:    hyst_chars = W'(8);
      4'h4:    hyst_chars = W'(8);
      4'h5:    hyst_chars = W'(16);
      4'h6:    hyst_chars = W'(24);
      4'h7:    hyst_chars = W'(32);
      4'h8:    hyst_chars = W'(40);
      4'h9:    hyst_chars = W'(44);
      4'ha:    hyst_chars = W'(48);
      4'hb:    hyst_chars = W'(52);
      4'hc:    hyst_chars = W'(12);
      4'hd:    hyst_chars = W'(20);
      4'he:    hyst_chars = W'(28);
      default: hyst_chars = W'(36);
    endcase
  endfunction

  logic [W-1:0] h;

  always_comb begin
    h     = hyst_chars(hyst_code);
    upper = next_up;
    lower = next_dn;
    if (trig_table == TABLE_D && hyst_code != 4'h0) begin
      upper = W'(rx_trig + h);
      lower = (rx_trig > h) ? W'(rx_trig - h) : '0;
    end
  end

endmodule
`default_nettype wire

// file: uart_enh_ctrl.sv
// Enhanced control logic of one UART channel: modem deltas,
// turnaround and halt byte, scratch, feature and enhanced bytes.
// Assumes shifters, FIFOs and modem control byte sit outside.
`timescale 1ns/100ps
`default_nettype none
module uart_enh_ctrl
  import uart_enh_pkg::*;
#(
  parameter int W = LEVEL_W
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire reg_sel_t      reg_sel,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [7:0]    reg_wdata,
  output var  logic [7:0]    reg_rdata_q,
  input  wire logic          cts_n,
  input  wire logic          dsr_n,
  input  wire logic          irda_rx,
  input  wire logic          msi_en,
  input  wire logic          flow_pin_sel,
  input  wire logic          rts_force,
  input  wire logic          dtr_force,
  input  wire logic          baud_tick,
  input  wire logic          tx_load,
  input  wire logic          thr_empty,
  input  wire logic          tsr_empty,
  input  wire logic          rx_busy,
  input  wire logic          rx_char_done,
  input  wire logic [W-1:0]  rx_level,
  input  wire logic [W-1:0]  rx_trig,
  input  wire logic [W-1:0]  next_up,
  input  wire logic [W-1:0]  next_dn,
  output var  logic          msi_irq_q,
  output var  logic          tx_irq_q,
  output var  logic          rx_trig_irq_q,
  output var  logic          tx_allow_q,
  output var  logic          rx_allow_q,
  output var  logic          rts_n_q,
  output var  logic          dtr_n_q,
  output var  logic          irda_rx_q,
  output var  logic          dual_flow_q,
  output var  logic [1:0]    trig_table_q
);

  feature_control_t  feature_control_q;
  enhanced_feature_t efr_q;
  turnaround_t       ta_q;
  logic [7:0]        scratch_q;
  logic              cts_prev_q;
  logic              dsr_prev_q;
  logic              d_cts_q;
  logic              d_dsr_q;
  logic              dir_q;
  logic [3:0]        ta_cnt_q;
  logic              rx_last_q;
  logic              flow_hold_q;
  logic              bit_tick;
  logic              tx_idle;
  logic              wr_sel_ms;
  logic              rd_ms;
  logic              flow_in_high;
  logic [W-1:0]      upper;
  logic [W-1:0]      lower;
  assign tx_idle   = thr_empty & tsr_empty;
  assign wr_sel_ms = reg_wr & (reg_sel == SEL_TURNAROUND);
  assign rd_ms     = reg_rd & (reg_sel == SEL_MODEM_STATUS);

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  bit_tick_div #(.TICKS(TICKS_PER_BIT)) u_div (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .restart   (!tx_idle),
    .baud_tick (baud_tick),
    .bit_tick  (bit_tick)
  );
  flow_threshold #(.W(W)) u_thr (
    .trig_table (feature_control_q.trig_table),
    .hyst_code  (feature_control_q.hyst),
    .rx_trig    (rx_trig),
    .next_up    (next_up),
    .next_dn    (next_dn),
    .upper      (upper),
    .lower      (lower)
  );

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // scratch byte
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scratch_q <= SCRATCH_RST;
    end else if (reg_wr && reg_sel == SEL_SCRATCH) begin
      scratch_q <= reg_wdata;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      feature_control_q <= feature_control_t'(FEATURE_RST);
    end else if (reg_wr && reg_sel == SEL_FEATURE) begin
      feature_control_q <= feature_control_t'(reg_wdata);
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      efr_q <= enhanced_feature_t'(ENHANCED_RST);
    end else if (reg_wr && reg_sel == SEL_ENHANCED) begin
      efr_q <= enhanced_feature_t'(reg_wdata);
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ta_q <= '0;
    end else if (wr_sel_ms) begin
      if (efr_q.enh_wr_en) begin
        ta_q.delay <= reg_wdata[7:4];
      end
      ta_q.tx_disable <= reg_wdata[3];
      ta_q.rx_disable <= reg_wdata[2];
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_sel)
        SEL_MODEM_STATUS: begin
          reg_rdata_q              <= 8'h00;
          reg_rdata_q[MS_DSR_BIT]  <= ~dsr_n;
          reg_rdata_q[MS_CTS_BIT]  <= ~cts_n;
          reg_rdata_q[MS_DDSR_BIT] <= d_dsr_q;
          reg_rdata_q[MS_DCTS_BIT] <= d_cts_q;
        end
        SEL_SCRATCH:  reg_rdata_q <= scratch_q;
        SEL_FEATURE:  reg_rdata_q <= feature_control_q;
        SEL_ENHANCED: reg_rdata_q <= efr_q;
        default:      reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Modem input change flags
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cts_prev_q <= 1'b1;
      dsr_prev_q <= 1'b1;
      d_cts_q    <= 1'b0;
      d_dsr_q    <= 1'b0;
      msi_irq_q  <= 1'b0;
    end else begin
      cts_prev_q <= cts_n;
      dsr_prev_q <= dsr_n;
      if (cts_n != cts_prev_q) begin
        d_cts_q <= 1'b1;
      end else if (rd_ms) begin
        d_cts_q <= 1'b0;
      end
      if (dsr_n != dsr_prev_q) begin
        d_dsr_q <= 1'b1;
      end else if (rd_ms) begin
        d_dsr_q <= 1'b0;
      end
      msi_irq_q  <= msi_en & (d_cts_q | d_dsr_q);
    end
  end

  // ------------------------------------------------------------
  // RS-485 direction and turnaround
  // ------------------------------------------------------------
  // direction follows transmitter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dir_q    <= 1'b0;
      ta_cnt_q <= 4'h0;
    end else if (!feature_control_q.rs485_en) begin
      dir_q    <= 1'b0;
      ta_cnt_q <= 4'h0;
    end else if (tx_load || !tx_idle) begin
      dir_q    <= 1'b1;
      ta_cnt_q <= 4'h0;
    end else if (dir_q) begin
      if (ta_cnt_q == ta_q.delay) begin
        dir_q <= 1'b0;
      end else if (bit_tick) begin
        ta_cnt_q <= ta_cnt_q + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit permission and interrupt
  // ------------------------------------------------------------
  // pick CTS or DSR
  assign flow_in_high = flow_pin_sel ? dsr_n : cts_n;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_allow_q <= 1'b0;
    end else if (tsr_empty) begin
      tx_allow_q <= !ta_q.tx_disable
                  && !(efr_q.auto_cts && flow_in_high)
                  && (!feature_control_q.rs485_en || dir_q);
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_irq_q <= 1'b0;
    end else begin
      tx_irq_q <= feature_control_q.rs485_en ? tx_idle : thr_empty;
    end
  end

  // ------------------------------------------------------------
  // Receive permission
  // ------------------------------------------------------------
  // one more character then stop
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_allow_q <= 1'b1;
      rx_last_q  <= 1'b0;
    end else if (!ta_q.rx_disable) begin
      rx_allow_q <= 1'b1;
      rx_last_q  <= 1'b0;
    end else if (!rx_last_q) begin
      rx_last_q <= 1'b1;
    end else if (rx_char_done) begin
      rx_allow_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Receive flow control
  // ------------------------------------------------------------
  // hold at or above upper, release below lower
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flow_hold_q <= 1'b0;
    end else if (!efr_q.auto_rts) begin
      flow_hold_q <= 1'b0;
    end else if (rx_level >= upper) begin
      flow_hold_q <= 1'b1;
    end else if (rx_level < lower) begin
      flow_hold_q <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_trig_irq_q <= 1'b0;
    end else begin
      rx_trig_irq_q <= rx_level >= rx_trig;
    end
  end
  // forced level stands when auto off, except RTS while RS-485 is enabled
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
    end else begin
      // RS-485 drives RTS high while sending
      if (feature_control_q.rs485_en) begin
        rts_n_q <= dir_q;
      end else begin
        rts_n_q <= !rts_force || (flow_hold_q && !flow_pin_sel);
      end
      dtr_n_q <= !dtr_force || (flow_hold_q && flow_pin_sel);
    end
  end

  // ------------------------------------------------------------
  // Miscellaneous outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irda_rx_q    <= 1'b0;
      dual_flow_q  <= 1'b0;
      trig_table_q <= 2'h0;
    end else begin
      irda_rx_q    <= irda_rx ^ feature_control_q.irda_rx_inv;
      dual_flow_q  <= efr_q.sw_flow == SW_FLOW_DUAL;
      trig_table_q <= feature_control_q.trig_table;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  dsr_delta_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dsr_n != $past(dsr_n)) |=> d_dsr_q)
    else $error("DSR change not flagged");
  cts_delta_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cts_n != $past(cts_n)) ##1 (msi_en && !rd_ms) |=> d_cts_q && msi_irq_q)
    else $error("CTS change lost or no interrupt");
  turnaround_wait_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dir_q && tx_idle && !tx_load && feature_control_q.rs485_en && ta_cnt_q != ta_q.delay)
    |=> dir_q)
    else $error("Direction dropped before delay");
  delay_lock_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_sel_ms && !efr_q.enh_wr_en) |=> $stable(ta_q.delay))
    else $error("Delay written while locked");
  tx_halt_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ta_q.tx_disable && tsr_empty) |=> !tx_allow_q)
    else $error("Transmit not halted");
  rx_stop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ta_q.rx_disable && rx_last_q && rx_char_done && !wr_sel_ms) |=> !rx_allow_q)
    else $error("Receiver not stopped");
  tx_irq_src_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (feature_control_q.rs485_en && !tsr_empty) |=> !tx_irq_q)
    else $error("Interrupt before shift empty");
  flow_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (efr_q.auto_rts && rx_level >= upper) |=> flow_hold_q)
    else $error("Flow hold not set");
  irda_pol_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> irda_rx_q == ($past(irda_rx) ^ $past(feature_control_q.irda_rx_inv)))
    else $error("IrDA polarity wrong");

endmodule
`default_nettype wire

// file: modem_line_model.sv
// Modem line model: drives CTS, DSR and IrDA receive levels.
// Assumes requests are set by nonblocking assignment at falling edges.
`timescale 1ns/100ps
`default_nettype none
module modem_line_model (
  input  wire logic sys_clk,
  input  wire logic cts_req,
  input  wire logic dsr_req,
  input  wire logic ir_req,
  output var  logic cts_n,
  output var  logic dsr_n,
  output var  logic irda_rx
);
  // ------------------------------------------------------------
  // Line drive
  // ------------------------------------------------------------
  initial begin
    cts_n = 1'b1;
    dsr_n = 1'b1;
    irda_rx = 1'b0;
  end
  always @(negedge sys_clk) begin
    cts_n <= cts_req;
    dsr_n <= dsr_req;
    irda_rx <= ir_req;
  end
endmodule
`default_nettype wire

// file: uart_enh_ctrl_test.sv
// Testbench for the enhanced UART control block.
// Assumes the modem line model and the design package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module uart_enh_ctrl_test;
  import uart_enh_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic sys_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, msi_en = 1'b0;
  logic pin_sel = 1'b0, rts_f = 1'b0, dtr_f = 1'b0, load = 1'b0, thr_e = 1'b1;
  logic tsr_e = 1'b1, rx_done = 1'b0, cts_lvl = 1'b1, dsr_lvl = 1'b1, ir_lvl = 1'b0;
  logic cts_n, dsr_n, irda_rx, msi_irq, tx_irq, trig_irq, tx_ok, rx_ok, rts_n, dtr_n, ir_q, dual;
  logic [1:0] tbl, t;
  logic [3:0] c, dd;
  logic [6:0] lev = 7'h00;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic [31:0] seed = 32'hff02;
  logic baud = 1'b0;
  reg_sel_t sel = SEL_MODEM_STATUS;
  int bad_count = 0, total_checks = 0, up, dn;
  int ht[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};

  always #2.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) baud <= ~baud;

  modem_line_model line_u (.sys_clk(sys_clk), .cts_req(cts_lvl), .dsr_req(dsr_lvl), .ir_req(ir_lvl),
    .cts_n(cts_n), .dsr_n(dsr_n), .irda_rx(irda_rx));
  uart_enh_ctrl dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_sel(sel), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata_q(rdata), .cts_n(cts_n), .dsr_n(dsr_n), .irda_rx(irda_rx),
    .msi_en(msi_en), .flow_pin_sel(pin_sel), .rts_force(rts_f), .dtr_force(dtr_f), .baud_tick(baud),
    .tx_load(load), .thr_empty(thr_e), .tsr_empty(tsr_e), .rx_busy(1'b0), .rx_char_done(rx_done),
    .rx_level(lev), .rx_trig(7'h3c), .next_up(7'h46), .next_dn(7'h32), .msi_irq_q(msi_irq),
    .tx_irq_q(tx_irq), .rx_trig_irq_q(trig_irq), .tx_allow_q(tx_ok), .rx_allow_q(rx_ok),
    .rts_n_q(rts_n), .dtr_n_q(dtr_n), .irda_rx_q(ir_q), .dual_flow_q(dual), .trig_table_q(tbl));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] q;
    q = s ^ (s << 13);
    q = q ^ (q >> 17);
    return q ^ (q << 5);
  endfunction
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr_reg(input reg_sel_t s, input logic [7:0] d);
    @(negedge sys_clk);
    sel = s;
    wdata = d;
    wr = 1'b1;
    @(negedge sys_clk);
    wr = 1'b0;
    gap(1);
  endtask
  task automatic rd_chk(input reg_sel_t s, input logic [7:0] e);
    @(negedge sys_clk);
    sel = s;
    rd = 1'b1;
    @(negedge sys_clk);
    rd = 1'b0;
    chk(s.name(), rdata, e);
  endtask
  task automatic line(input logic cl, input logic dl);
    cts_lvl <= cl;
    dsr_lvl <= dl;
    gap(4);
  endtask
  task automatic lvl(input int x, input logic e);
    lev = 7'(x);
    gap(3);
    chk("flow_pin", 8'(pin_sel ? dtr_n : rts_n), 8'(e));
    chk("rx_trig_irq", 8'(trig_irq), 8'(x >= 60));
  endtask
  task automatic turn(input int d);
    int n;
    thr_e = 1'b0;
    tsr_e = 1'b0;
    load = 1'b1;
    @(negedge sys_clk);
    load = 1'b0;
    gap(2);
    chk("rts_dir", 8'(rts_n), 8'h01);
    thr_e = 1'b1;
    gap(2);
    chk("tx_irq", 8'(tx_irq), 8'h00);
    tsr_e = 1'b1;
    n = 0;
    while (rts_n !== 1'b0 && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    chk("turn_delay", 8'(n >= 2 * TICKS_PER_BIT * d && n <= 2 * TICKS_PER_BIT * d + 6), 8'h01);
    chk("tx_irq", 8'(tx_irq), 8'h01);
  endtask
  task automatic close_out;
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    rd_chk(SEL_SCRATCH, SCRATCH_RST);
    rd_chk(SEL_FEATURE, 8'h00);
    rd_chk(SEL_ENHANCED, 8'h00);
    rd_chk(SEL_TURNAROUND, 8'h00);
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      v = seed[7:0];
      wr_reg(SEL_SCRATCH, v);
      rd_chk(SEL_SCRATCH, v);
    end
    rd_chk(SEL_MODEM_STATUS, 8'h00);
    msi_en = 1'b1;
    line(1'b0, 1'b1);
    chk("msi_irq", 8'(msi_irq), 8'h01);
    rd_chk(SEL_MODEM_STATUS, 8'h11);
    rd_chk(SEL_MODEM_STATUS, 8'h10);
    gap(2);
    chk("msi_irq", 8'(msi_irq), 8'h00);
    msi_en = 1'b0;
    line(1'b0, 1'b0);
    chk("msi_irq", 8'(msi_irq), 8'h00);
    rd_chk(SEL_MODEM_STATUS, 8'h32);
    wr_reg(SEL_ENHANCED, 8'h10);
    wr_reg(SEL_FEATURE, 8'h20);
    seed = xs(seed);
    dd = (seed[3:0] == 4'h5) ? 4'h6 : seed[3:0];
    foreach (ht[i]) if (i < 3) begin
      c = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : dd;
      wr_reg(SEL_TURNAROUND, {c, 4'h0});
      turn(c);
    end
    wr_reg(SEL_ENHANCED, 8'h00);
    wr_reg(SEL_TURNAROUND, 8'h50);
    turn(dd);
    wr_reg(SEL_FEATURE, 8'h00);
    tsr_e = 1'b0;
    gap(2);
    chk("tx_irq", 8'(tx_irq), 8'h01);
    tsr_e = 1'b1;
    gap(2);
    chk("tx_allow", 8'(tx_ok), 8'h01);
    wr_reg(SEL_TURNAROUND, 8'h08);
    chk("tx_allow", 8'(tx_ok), 8'h00);
    wr_reg(SEL_TURNAROUND, 8'h00);
    chk("tx_allow", 8'(tx_ok), 8'h01);
    wr_reg(SEL_ENHANCED, 8'h80);
    for (int p = 0; p < 2; p++) begin
      pin_sel = p[0];
      line(p == 0, p == 1);
      chk("tx_allow", 8'(tx_ok), 8'h00);
      line(p == 1, p == 0);
      chk("tx_allow", 8'(tx_ok), 8'h01);
      tsr_e = 1'b0;
      line(p == 0, p == 1);
      chk("tx_allow", 8'(tx_ok), 8'h01);
      tsr_e = 1'b1;
      gap(2);
      chk("tx_allow", 8'(tx_ok), 8'h00);
      line(1'b0, 1'b0);
    end
    // dual characters, cleared before each change
    wr_reg(SEL_ENHANCED, 8'h00);
    wr_reg(SEL_ENHANCED, 8'h0f);
    chk("dual_flow", 8'(dual), 8'h01);
    wr_reg(SEL_ENHANCED, 8'h00);
    wr_reg(SEL_ENHANCED, 8'h0b);
    chk("dual_flow", 8'(dual), 8'h00);
    rd_chk(SEL_ENHANCED, 8'h0b);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      wr_reg(SEL_FEATURE, {3'b000, seed[0], 4'h0});
      ir_lvl <= seed[1];
      gap(4);
      chk("irda_rx", 8'(ir_q), 8'(seed[1] ^ seed[0]));
    end
    wr_reg(SEL_ENHANCED, 8'h00);
    wr_reg(SEL_ENHANCED, 8'h40);
    rts_f = 1'b1;
    dtr_f = 1'b1;
    for (int i = 0; i < 20; i++) begin
      t = (i < 16) ? TABLE_D : 2'(i - 16);
      c = 4'(i);
      up = (t == TABLE_D && c != 4'h0) ? 60 + ht[c] : 70;
      dn = (t == TABLE_D && c != 4'h0) ? 60 - ht[c] : 50;
      pin_sel = c[0];
      wr_reg(SEL_FEATURE, {t, 2'b00, c});
      chk("trig_table", 8'(tbl), 8'(t));
      lvl(up - 1, 1'b0);
      lvl(up, 1'b1);
      lvl(dn, 1'b1);
      lvl(dn - 1, 1'b0);
    end
    wr_reg(SEL_TURNAROUND, 8'h04);
    chk("rx_allow", 8'(rx_ok), 8'h01);
    rx_done = 1'b1;
    @(negedge sys_clk);
    rx_done = 1'b0;
    gap(2);
    chk("rx_allow", 8'(rx_ok), 8'h00);
    wr_reg(SEL_TURNAROUND, 8'h00);
    chk("rx_allow", 8'(rx_ok), 8'h01);
    close_out();
  end
endmodule
`default_nettype wire
